// >>> design/spwm_channel.sv
`timescale 1ns/1ps
`default_nettype none
module spwm_channel
    import spwm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register writes
    input wire logic ctl_wr,
    input wire logic duty_high_wr,
    input wire logic duty_low_wr,
    input wire logic tsel_wr,
    input wire logic [7:0] wr_data,
    // register readback
    output logic [7:0] unit_control_rd,
    output logic [7:0] duty_high_rd,
    output logic [7:0] duty_low_rd,
    output logic [7:0] timer_source_select_rd,
    // timebase timers
    input wire logic [2:0][7:0] tmr_count,
    input wire logic [2:0][7:0] tmr_period,
    input wire logic [2:0][2:0] tmr_timebase_prescale_field,
    input wire logic [2:0][1:0] tmr_prebits,
    input wire logic [2:0] tmr_tick,
    output logic instr_tick,
    // pin and internal consumers
    input wire logic pin_direction_bit,
    output logic pwm_output_pin_out,
    output logic pwm_output_pin_oe,
    output logic pwm_internal_out,
    // status
    output logic pwm_active,
    output logic [3:0] pwm_resolution
);

    logic [1:0] rst_sync_q;
    logic rst_n_int;
    spwm_regs_t r_q;
    spwm_regs_t r_d;
    logic [7:0] sel_period;
    logic sel_boundary;
    logic [9:0] sel_tb;
    logic [9:0] duty_asm;
    logic pwm_mode;
    logic [7:0] ctl_wdata;

    // reset released through two flops, asserted at once
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n_int = rst_sync_q[1];

    spwm_tb_sel u_tb_sel
    (
        .tsel(r_q.tsel),
        .phase(r_q.phase),
        .tmr_count(tmr_count),
        .tmr_period(tmr_period),
        .tmr_timebase_prescale_field(tmr_timebase_prescale_field),
        .tmr_prebits(tmr_prebits),
        .tmr_tick(tmr_tick),
        .sel_period(sel_period),
        .sel_boundary(sel_boundary),
        .sel_tb(sel_tb)
    );

    spwm_duty_fmt u_duty_fmt
    (
        .duty_high(r_q.dh),
        .duty_low(r_q.dl),
        .fmt(r_q.ctl[CTL_FMT_POS]),
        .duty(duty_asm)
    );

    assign pwm_mode = r_q.ctl[CTL_EN_POS] &
        (r_q.ctl[CTL_MODE_HI:CTL_MODE_LO] == CTL_MODE_PWM);

    // the output data bit is read-only, so it is never stored from a write
    assign ctl_wdata = wr_data & ~(8'h01 << CTL_OUT_POS);

    function automatic logic [3:0] res_of(input logic [7:0] pr);
        logic [8:0] n;
        logic [3:0] res;
        n = {1'b0, pr} + 9'h001;
        res = 4'h2;
        for (int k = 1; k < 9; k++)
        begin
            if (n[k])
            begin
                res = 4'(k + 2);
            end
        end
        return res;
    endfunction

    always_comb
    begin
        r_d = r_q;
        // instruction phase runs straight off the system clock
        r_d.phase = r_q.phase + 2'h1;

        if (ctl_wr)
        begin
            r_d.ctl = ctl_wdata;
        end
        // duty writes accepted at any time
        if (duty_high_wr)
        begin
            r_d.dh = wr_data;
        end
        if (duty_low_wr)
        begin
            r_d.dl = wr_data;
        end
        if (tsel_wr)
        begin
            r_d.tsel = wr_data[TSEL_W-1:0];
        end
        // resolution registered from period in use
        r_d.res = res_of(sel_period);

        unique case (r_q.st)
            ST_OFF:
            begin
                // compare latch forced low while idle
                r_d.out = 1'b0;
                if (pwm_mode)
                begin
                    r_d.st = ST_ARMED;
                end
            end
            ST_ARMED, ST_RUN:
            begin
                if (!pwm_mode)
                begin
                    r_d.st = ST_OFF;
                    r_d.out = 1'b0;
                end
                // period match restarts and latches duty
                else if (sel_boundary)
                begin
                    r_d.st = ST_RUN;
                    r_d.duty_buf = duty_asm;
                    // set at restart unless duty is zero
                    r_d.out = (duty_asm != 10'h000);
                end
                // clear on timebase match; no match keeps level
                else if (r_q.st == ST_RUN && sel_tb == r_q.duty_buf)
                begin
                    r_d.out = 1'b0;
                end
            end
            default:
            begin
                r_d.st = ST_OFF;
                r_d.out = 1'b0;
            end
        endcase

        // drive only in pwm mode, output enabled, direction cleared
        r_d.oe = (r_d.st != ST_OFF) & r_d.ctl[CTL_OE_POS] & ~pin_direction_bit;
    end

    // every register returns to its reset value
    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            r_q.st <= ST_OFF;
            r_q.ctl <= CTL_RESET;
            r_q.dh <= DUTY_RESET;
            r_q.dl <= DUTY_RESET;
            r_q.tsel <= TSEL_RESET;
            r_q.phase <= 2'h0;
            r_q.duty_buf <= DUTY_BUF_RESET;
            r_q.out <= 1'b0;
            r_q.oe <= 1'b0;
            r_q.res <= RES_RESET;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // instruction clock offered to the timebase timers
    assign instr_tick = (r_q.phase == PHASE_LAST);

    assign pwm_output_pin_out = r_q.out;
    assign pwm_output_pin_oe = r_q.oe;
    // waveform to internal consumers regardless of pin enable
    assign pwm_internal_out = r_q.out;
    assign pwm_active = (r_q.st == ST_RUN);
    assign pwm_resolution = r_q.res;

    always_comb
    begin
        unit_control_rd = r_q.ctl;
        unit_control_rd[CTL_OUT_POS] = r_q.out;
    end

    assign duty_high_rd = r_q.dh;
    assign duty_low_rd = r_q.dl;
    assign timer_source_select_rd = {6'h00, r_q.tsel};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n_int);

    sequence s_restart;
        (r_q.st != ST_OFF) && pwm_mode && sel_boundary;
    endsequence

    sequence s_run_match;
        (r_q.st == ST_RUN) && pwm_mode && !sel_boundary && (sel_tb == r_q.duty_buf);
    endsequence

    sequence s_phase_cycle;
        instr_tick ##1 !instr_tick [*3] ##1 instr_tick;
    endsequence

    sequence s_mid_period;
        (r_q.st == ST_RUN) && pwm_mode && !sel_boundary;
    endsequence

    sequence s_enter;
        (r_q.st == ST_OFF) && pwm_mode;
    endsequence

    pin_release_a:
    assert property ((r_q.ctl == 8'h00) |-> !pwm_output_pin_oe)
        else $error("pin driven with control register cleared");

    dir_gate_a:
    assert property (pin_direction_bit |=> !pwm_output_pin_oe)
        else $error("pin driven with direction bit set");

    restart_high_a:
    assert property ((s_restart and (duty_asm != 10'h000)) |=> pwm_output_pin_out)
        else $error("pin not set at period restart");

    zero_duty_a:
    assert property ((s_restart and (duty_asm == 10'h000)) |=> !pwm_output_pin_out)
        else $error("pin set with zero duty");

    duty_latch_a:
    assert property (s_restart |=> (r_q.duty_buf == $past(duty_asm)) && pwm_active)
        else $error("duty not latched at period match");

    buf_hold_a:
    assert property (((r_q.st == ST_RUN) && pwm_mode && !sel_boundary) |=> $stable(r_q.duty_buf))
        else $error("duty buffer changed mid-period");

    match_low_a:
    assert property (s_run_match |=> !pwm_output_pin_out)
        else $error("pin not cleared on duty match");

    hold_over_a:
    assert property (((r_q.st == ST_RUN) && pwm_mode && !sel_boundary &&
        (r_q.duty_buf > {sel_period, 2'h3})) |=> $stable(pwm_output_pin_out))
        else $error("pin changed with duty above period");

    phase_tick_a:
    assert property (instr_tick |-> s_phase_cycle)
        else $error("instruction tick not every four clocks");

    mode_off_a:
    assert property (!pwm_mode |=> (r_q.st == ST_OFF) ##1 !pwm_output_pin_out)
        else $error("unit left pwm mode but kept running");

    full_res_a:
    assert property ((sel_period == 8'hff) |=> (pwm_resolution == 4'ha))
        else $error("full period does not give ten bits");

    min_res_a:
    assert property ((sel_period == 8'h00) |=> (pwm_resolution == 4'h2))
        else $error("smallest period does not give two bits");

    oe_mode_a:
    assert property (!pwm_mode |=> !pwm_output_pin_oe)
        else $error("pin driven outside pwm mode");

    off_low_a:
    assert property ((r_q.st == ST_OFF) |=> !pwm_output_pin_out)
        else $error("output latch not low while idle");

    oe_drive_a:
    assert property ((pwm_mode && r_q.ctl[CTL_OE_POS] && !pin_direction_bit && !ctl_wr)
        |=> pwm_output_pin_oe)
        else $error("pin not driven in pwm mode");

    enter_armed_a:
    assert property (s_enter |=> (r_q.st == ST_ARMED))
        else $error("pwm mode did not arm the unit");

    armed_low_a:
    assert property ((r_q.st == ST_ARMED) |-> !pwm_output_pin_out)
        else $error("pin high before first restart");

    rise_restart_a:
    assert property (!(sel_boundary && pwm_mode && (r_q.st != ST_OFF))
        |=> !$rose(pwm_output_pin_out))
        else $error("pin rose away from a restart");

    zero_hold_a:
    assert property (((r_q.st == ST_RUN) && (r_q.duty_buf == 10'h000))
        |-> !pwm_output_pin_out)
        else $error("pin high with zero duty latched");

    low_hold_a:
    assert property ((s_mid_period and !pwm_output_pin_out) |=> !pwm_output_pin_out)
        else $error("pin set again within the period");

    ctl_take_a:
    assert property (ctl_wr |=> ((unit_control_rd & 8'hdf) == ($past(wr_data) & 8'hdf)))
        else $error("control write not stored");

    dh_take_a:
    assert property (duty_high_wr |=> (duty_high_rd == $past(wr_data)))
        else $error("duty high write not stored");

    dl_take_a:
    assert property (duty_low_wr |=> (duty_low_rd == $past(wr_data)))
        else $error("duty low write not stored");

    tsel_take_a:
    assert property (tsel_wr |=> (timer_source_select_rd == {6'h00, $past(wr_data[1:0])}))
        else $error("timer select write not stored");

endmodule // spwm_channel
`default_nettype wire

// >>> design/spwm_pkg.sv
// Overview of operation
// - pwm waveform on output pin, up to ten-bit resolution
// - all-zero control write releases the pin
// - unit picks one of three timebase timers
// - period is (period+1) x 4 x prescale clocks
// - at period match: restart, latch duty buffer
// - restart sets pin, except zero duty
// - timer postscaler ignored for pwm period
// - alignment zero: high[1:0], low[7:0]
// - alignment one: high[7:0], low[7:6]
// - duty writes anytime, applied next period
// - timebase low bits: clock phase or prescaler
// - timebase equal duty buffer clears pin
// - resolution log2(4(period+1)), ten at 255
// - duty above period leaves pin unchanged
// - timing scales directly with system clock
// - reset restores registers, pin becomes input
// - waveform also offered to internal blocks
package spwm_pkg;

    // unit control register layout
    localparam int unsigned CTL_EN_POS = 7;
    localparam int unsigned CTL_OE_POS = 6;
    localparam int unsigned CTL_OUT_POS = 5;
    localparam int unsigned CTL_FMT_POS = 4;
    localparam int unsigned CTL_MODE_HI = 3;
    localparam int unsigned CTL_MODE_LO = 2;
    localparam logic [1:0] CTL_MODE_PWM = 2'h3;

    // reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [1:0] TSEL_RESET = 2'h0;
    localparam logic [9:0] DUTY_BUF_RESET = 10'h000;
    localparam logic [3:0] RES_RESET = 4'h2;

    // timebase timers
    localparam int unsigned NUM_TIMERS = 3;
    localparam int unsigned TSEL_W = 2;
    localparam int unsigned TIMEBASE_PRESCALE_FIELD_W = 3;
    localparam logic [2:0] TIMEBASE_PRESCALE_FIELD_1TO1 = 3'h0;
    localparam int unsigned TB_W = 10;

    // instruction clock is the system clock over four
    localparam int unsigned CLK_PERIOD_PS = 25000;
    localparam int unsigned INSTR_PERIOD_PS = 100000;
    localparam int unsigned INSTR_CYCLES = INSTR_PERIOD_PS / CLK_PERIOD_PS;
    localparam logic [1:0] PHASE_LAST = 2'(INSTR_CYCLES - 1);

    typedef enum logic [1:0]
    {
        ST_OFF = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN = 2'b11
    } spwm_state_t;

    typedef struct packed
    {
        spwm_state_t st;
        logic [7:0] ctl;
        logic [7:0] dh;
        logic [7:0] dl;
        logic [1:0] tsel;
        logic [1:0] phase;
        logic [9:0] duty_buf;
        logic out;
        logic oe;
        logic [3:0] res;
    } spwm_regs_t;

endpackage

// >>> design/spwm_tb_sel.sv
`timescale 1ns/1ps
`default_nettype none
module spwm_tb_sel
    import spwm_pkg::*;
(
    // selection
    input wire logic [1:0] tsel,
    input wire logic [1:0] phase,
    // timers
    input wire logic [2:0][7:0] tmr_count,
    input wire logic [2:0][7:0] tmr_period,
    input wire logic [2:0][2:0] tmr_timebase_prescale_field,
    input wire logic [2:0][1:0] tmr_prebits,
    input wire logic [2:0] tmr_tick,
    // selected timer
    output logic [7:0] sel_period,
    output logic sel_boundary,
    output logic [9:0] sel_tb
);

    logic [2:0][7:0] g_count;
    logic [2:0][7:0] g_period;
    logic [2:0][9:0] g_tb;
    logic [2:0] g_bnd;
    logic [1:0] idx;

    // an unused select code falls back to the first timer
    assign idx = (tsel < 2'(NUM_TIMERS)) ? tsel : 2'h0;

    genvar i;
    generate
        for (i = 0; i < NUM_TIMERS; i++)
        begin : g_tmr
            logic hit;
            assign hit = (idx == 2'(i));
            assign g_period[i] = hit ? tmr_period[i] : 8'h00;
            assign g_count[i] = hit ? tmr_count[i] : 8'h00;
            // postscaler plays no part: boundary is the raw match
            assign g_bnd[i] = hit & tmr_tick[i] & (tmr_count[i] == tmr_period[i]);
            // low bits from clock phase at 1:1
            assign g_tb[i] = !hit ? 10'h000 :
                (tmr_timebase_prescale_field[i] == TIMEBASE_PRESCALE_FIELD_1TO1) ? {g_count[i], phase} :
                {g_count[i], tmr_prebits[i]};
        end
    endgenerate

    assign sel_period = g_period[0] | g_period[1] | g_period[2];
    assign sel_boundary = |g_bnd;
    assign sel_tb = g_tb[0] | g_tb[1] | g_tb[2];

endmodule // spwm_tb_sel
`default_nettype wire

// >>> design/spwm_duty_fmt.sv
`timescale 1ns/1ps
`default_nettype none
module spwm_duty_fmt
    import spwm_pkg::*;
(
    // duty registers
    input wire logic [7:0] duty_high,
    input wire logic [7:0] duty_low,
    input wire logic fmt,
    // assembled ten-bit duty value
    output logic [9:0] duty
);

    always_comb
    begin
        duty = {duty_high[1:0], duty_low};
        if (fmt)
        begin
            duty = {duty_high, duty_low[7:6]};
        end
    end

endmodule // spwm_duty_fmt
`default_nettype wire

// >>> dv/spwm_tmr_model.sv
`timescale 1ns/1ps
`default_nettype none
module spwm_tmr_model
    import spwm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // settings
    input wire logic instr_tick,
    input wire logic [2:0][7:0] period,
    input wire logic [2:0][2:0] timebase_prescale_field,
    // timer state
    output logic [2:0][7:0] count,
    output logic [2:0][1:0] prebits,
    output logic [2:0] tick
);
    // instruction clock, no postscaler
    // any nonzero prescale field counts 1:4 here, the only ratio the bench needs
    always_comb
        for (int i = 0; i < 3; i++)
            tick[i] = instr_tick && (timebase_prescale_field[i] == TIMEBASE_PRESCALE_FIELD_1TO1 || prebits[i] == 2'h3);
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
        begin
            count <= '0;
            prebits <= '0;
        end
        else
            for (int i = 0; i < 3; i++)
            begin
                if (instr_tick)
                    prebits[i] <= prebits[i] + 2'h1;
                if (tick[i])
                    count[i] <= (count[i] == period[i]) ? 8'h00 : count[i] + 8'h01;
            end
endmodule // spwm_tmr_model
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, reset_n = 0, dir = 1, skip = 0, prev = 0;
    logic [3:0] wstb = 4'h0;
    logic [7:0] wr_data = 8'h00, ctl_rd, dh_rd, dl_rd, ts_rd;
    logic [2:0][7:0] tcnt, tper = {8'h0f, 8'h03, 8'h07};
    logic [2:0][2:0] tckps = {3'h0, 3'h1, 3'h0};
    logic [2:0][1:0] tpre;
    logic [2:0] ttick;
    logic itick, pin, oe, iout, act;
    logic [3:0] res;
    logic [7:0] pv[6] = '{8'hff, 8'h3f, 8'h1f, 8'h17, 8'h01, 8'h00};
    int num_errors = 0, n_checks = 0, seed = 82;
    integer nh = 0, np = 0;
    int qh[$], qp[$];

    always #12.5 clk = ~clk;

    spwm_channel u_dut (.clk(clk), .reset_n(reset_n), .ctl_wr(wstb[0]),
        .duty_high_wr(wstb[1]), .duty_low_wr(wstb[2]), .tsel_wr(wstb[3]),
        .wr_data(wr_data), .unit_control_rd(ctl_rd), .duty_high_rd(dh_rd),
        .duty_low_rd(dl_rd), .timer_source_select_rd(ts_rd), .tmr_count(tcnt),
        .tmr_period(tper), .tmr_timebase_prescale_field(tckps), .tmr_prebits(tpre), .tmr_tick(ttick),
        .instr_tick(itick), .pin_direction_bit(dir), .pwm_output_pin_out(pin),
        .pwm_output_pin_oe(oe), .pwm_internal_out(iout), .pwm_active(act),
        .pwm_resolution(res));
    spwm_tmr_model u_tmr (.clk(clk), .reset_n(reset_n), .instr_tick(itick),
        .period(tper), .timebase_prescale_field(tckps), .count(tcnt), .prebits(tpre), .tick(ttick));

    task automatic chk_v(string name, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", name, e, g);
        end
    endtask

    task automatic chk_n(string name, integer e, integer g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %0d seen %0d", name, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(int k, logic [7:0] d);
        @(posedge clk);
        #1 wr_data = d;
        wstb = 4'h1 << k;
        @(posedge clk);
        #1 wstb = 4'h0;
    endtask

    function automatic logic [31:0] exp_res(int p);
        logic [31:0] r;
        r = 2;
        for (int v = p + 1; v > 1; v = v >> 1)
            r++;
        return r;
    endfunction

    // the registered clear adds one cycle to every pulse
    task automatic run(logic [1:0] ts, logic fmt, logic [7:0] dh, logic [7:0] dl, int n);
        logic [9:0] d;
        int t;
        int s;
        d = fmt ? {dh, dl[7:6]} : {dh[1:0], dl};
        t = (ts == 2'h3) ? 0 : int'(ts);
        s = (tckps[t] == 3'h0) ? 1 : 4;
        wr(3, {6'h0, ts});
        wr(0, 8'hcc | {3'h0, fmt, 4'h0});
        wr(1, dh);
        wr(2, dl);
        chk_v("readback", {8'hcc | {3'h0, fmt, 4'h0}, dh, dl, 6'h0, ts},
            {ctl_rd & 8'hdf, dh_rd, dl_rd, ts_rd});
        if (n > 0)
        begin
            repeat (2) @(posedge pin);
            skip = 1;
            repeat (n)
            begin
                qh.push_back(int'(d) * s + 1);
                qp.push_back(4 * (int'(tper[t]) + 1) * s);
            end
            wait (qh.size() == 0);
        end
        $display("test duty %0d done", d);
    endtask

    task automatic count_high(string name, int e);
        integer n;
        n = 0;
        repeat (64) @(posedge clk);
        repeat (64)
        begin
            @(negedge clk);
            n += pin;
        end
        chk_n(name, e, n);
        $display("test %s done", name);
    endtask

    always @(negedge clk)
    begin
        if (pin && !prev)
        begin
            if (!skip && qh.size() > 0)
            begin
                chk_n("pulse high", qh.pop_front(), nh);
                chk_n("pulse period", qp.pop_front(), np);
                chk_v("internal copy", 32'h1, {31'h0, iout});
            end
            skip = 0;
            nh = 0;
            np = 0;
        end
        nh += pin;
        np++;
        prev = pin;
    end

    initial
    begin
        repeat (3) @(posedge clk);
        #1 reset_n = 1;
        repeat (3) @(posedge clk);
        #1 chk_v("reset regs", 32'h0, {ctl_rd, dh_rd, dl_rd, ts_rd});
        chk_v("reset pin", 32'h0, {29'h0, act, oe, pin});
        run(0, 0, 8'h00, 8'h05, 0);
        chk_v("oe while input", 32'h0, {31'h0, oe});
        dir = 0;
        run(0, 0, 8'h00, 8'h05, 2);
        chk_v("driving", 32'h3, {30'h0, oe, act});
        run(0, 0, 8'hfc, 8'h1e, 2);
        run(2, 1, 8'h05, 8'h80, 2);
        run(1, 1, 8'h01, 8'h40, 2);
        run(3, 0, 8'h00, 8'h09, 2);
        repeat (3) run(0, 0, 8'h00, 8'(1 + $unsigned($random(seed)) % 30), 2);
        run(0, 0, 8'h00, 8'h09, 0);
        @(posedge pin);
        skip = 1;
        qh.push_back(10);
        qp.push_back(32);
        qh.push_back(21);
        qp.push_back(32);
        wr(2, 8'h14);
        wait (qh.size() == 0);
        $display("test double buffer done");
        run(0, 0, 8'h00, 8'h00, 0);
        count_high("zero duty", 0);
        run(0, 0, 8'h00, 8'h28, 0);
        count_high("above period", 64);
        wr(0, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk_v("released", 32'h0, {30'h0, oe, pin});
        run(0, 0, 8'h00, 8'h05, 2);
        wr(0, 8'hc8);
        count_high("other mode", 0);
        chk_v("mode off", 32'h0, {30'h0, oe, act});
        foreach (pv[i])
        begin
            @(posedge clk);
            #1 tper[0] = pv[i];
            @(posedge clk);
            #1 chk_v("resolution", exp_res(pv[i]), {28'h0, res});
        end
        $display("test resolution done");
        stop_test();
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        $display("Error watchdog expected end seen hang");
        stop_test();
    end
endmodule // tb
`default_nettype wire
